//--- verilog/cogr_pkg.sv
// Package with register offsets, reset values and encodings of the colour offset/gain bank.
`default_nettype none
package cogr_pkg;
  // Width of the register address and of every stored code.
  localparam int ADR_W = 4;
  localparam int CODE_W = 8;
  localparam int NREG = 6;
  // Register offsets on the plain register port.
  localparam logic [ADR_W-1:0] ADR_RED_OFS = 4'h0;
  localparam logic [ADR_W-1:0] ADR_GRN_OFS = 4'h1;
  localparam logic [ADR_W-1:0] ADR_BLU_OFS = 4'h2;
  localparam logic [ADR_W-1:0] ADR_ALL_OFS = 4'h3;
  localparam logic [ADR_W-1:0] ADR_RED_GAIN = 4'h4;
  localparam logic [ADR_W-1:0] ADR_GRN_GAIN = 4'h5;
  localparam logic [ADR_W-1:0] ADR_BLU_GAIN = 4'h6;
  localparam logic [ADR_W-1:0] ADR_ALL_GAIN = 4'h7;
  localparam logic [ADR_W-1:0] ADR_CTRL = 4'h8;
  localparam logic [ADR_W-1:0] ADR_STAT = 4'h9;
  // Reset values of the stored codes.
  localparam logic [CODE_W-1:0] RST_OFS = 8'h80;
  localparam logic [CODE_W-1:0] RST_GAIN = 8'h00;
  localparam logic [CODE_W-1:0] RST_CTRL = 8'h00;
  // Storage slots: 0..2 offsets red/green/blue, 3..5 gains red/green/blue.
  localparam int SLOT_RED_OFS = 0;
  localparam int SLOT_GRN_OFS = 1;
  localparam int SLOT_BLU_OFS = 2;
  localparam int SLOT_RED_GAIN = 3;
  localparam int SLOT_GRN_GAIN = 4;
  localparam int SLOT_BLU_GAIN = 5;
  localparam logic [ADR_W-1:0] SLOT_ADR [0:NREG-1] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
  localparam logic [ADR_W-1:0] SLOT_BCAST [0:NREG-1] = '{4'h3, 4'h3, 4'h3, 4'h7, 4'h7, 4'h7};
  localparam logic [CODE_W-1:0] SLOT_RST [0:NREG-1] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  // Control register fields.
  localparam int CTRL_MUX_LSB = 0;
  localparam int CTRL_TEST_BIT = 7;
  localparam logic [CODE_W-1:0] CTRL_MASK = 8'h83;
  // Colour multiplexing select encodings.
  localparam logic [1:0] MUX_RED = 2'h0;
  localparam logic [1:0] MUX_GREEN = 2'h1;
  localparam logic [1:0] MUX_BLUE = 2'h2;
  localparam logic [1:0] MUX_ROTATE = 2'h3;
  // Active colour, one-hot.
  typedef enum logic [2:0] {
    COL_RED = 3'h1,
    COL_GREEN = 3'h2,
    COL_BLUE = 3'h4
  } cogr_colour_t;
endpackage
`default_nettype wire

//--- verilog/cogr_reg_if.sv
// Interface between the bank decoder and one stored code register.
`timescale 1ns/1ps
`default_nettype none
interface cogr_reg_if #(parameter int W = 8) ();
  logic ld;
  logic [W-1:0] din;
  logic [W-1:0] q;
  modport ctl (output ld, output din, input q);
  modport store (input ld, input din, output q);
endinterface
`default_nettype wire

//--- verilog/cogr_code_reg.sv
// One stored 8-bit code with its own reset value, loaded through the register interface.
`timescale 1ns/1ps
`default_nettype none
module cogr_code_reg
  import cogr_pkg::*;
#(
  parameter int W = CODE_W,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys_i, // System clock.
  input wire logic rstn_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable; state holds while low.
  cogr_reg_if.store bus // Load strobe, data and stored value.
);
  logic [W-1:0] code_d;
  logic [W-1:0] code_q;

  // Next value: the loaded data, otherwise hold.
  always_comb begin
    code_d = bus.ld ? bus.din : code_q;
  end

  // Storage flop.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      code_q <= RST;
    end else if (ce_i) begin
      code_q <= code_d;
    end
  end

  assign bus.q = code_q;
endmodule // cogr_code_reg
`default_nettype wire

//--- verilog/cogr_bank.sv
// Colour offset and gain register bank with colour multiplexing and clock test output.
`timescale 1ns/1ps
`default_nettype none
module cogr_bank
  import cogr_pkg::*;
#(
  parameter int DATA_W = CODE_W
) (
  input wire logic clk_sys_i, // System clock, 250 MHz.
  input wire logic rstn_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable; all state holds while low.
  input wire logic [ADR_W-1:0] addr_i, // Register address.
  input wire logic [DATA_W-1:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe, one cycle.
  input wire logic rd_i, // Read strobe, one cycle.
  output logic [DATA_W-1:0] rdata_o, // Read data, the cycle after the strobe.
  input wire logic line_sync_i, // Line start pin, asynchronous; steps the rotating colour.
  input wire logic [3:0] conv_nibble_i, // Converter data nibble, same clock.
  input wire logic sample_sync_i, // Internal sample sync pulse, same clock.
  input wire logic video_clk_i, // Video sample clock, same clock.
  input wire logic conv_clk_i, // Converter clock, same clock.
  input wire logic reset_clk_i, // Reset sample clock, same clock.
  output logic [CODE_W-1:0] offset_code_o, // Offset code of the active colour.
  output logic [CODE_W-1:0] gain_value_o, // Gain code of the active colour.
  output logic [2:0] active_colour_o, // Active colour, one-hot red/green/blue.
  output logic [3:0] nibble_data_out_o // Data output pins.
);

  // Narrower data could not carry a whole code.
  if (DATA_W < CODE_W) begin : g_bad_width
    $error("DATA_W must be at least the code width");
  end

  // Stored code values as seen by the bank.
  logic [CODE_W-1:0] val [0:NREG-1];
  logic [CODE_W-1:0] wcode;

  assign wcode = wdata_i[CODE_W-1:0];

  // One storage register per slot; each listens to its own address
  // and to the broadcast address of its group.
  for (genvar i = 0; i < NREG; i++) begin : g_slot
    cogr_reg_if #(.W(CODE_W)) rif ();
    cogr_code_reg #(
      .W(CODE_W),
      .RST(SLOT_RST[i])
    ) u_reg (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .bus(rif.store)
    );
    // Own address or group broadcast.
    assign rif.ld = wr_i && (addr_i == SLOT_ADR[i] || addr_i == SLOT_BCAST[i]);
    assign rif.din = wcode;
    assign val[i] = rif.q;
  end

  // Control register: colour select and clock test bit.
  logic [CODE_W-1:0] ctrl_d;
  logic [CODE_W-1:0] ctrl_q;
  logic [1:0] mux_sel;
  logic test_en;

  assign mux_sel = ctrl_q[CTRL_MUX_LSB +: 2];
  assign test_en = ctrl_q[CTRL_TEST_BIT];

  // Only the defined control bits are kept; the rest read as zero.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_i && addr_i == ADR_CTRL) begin
      ctrl_d = wcode & CTRL_MASK;
    end
  end

  // Control flop.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ctrl_q <= RST_CTRL;
    end else if (ce_i) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Line sync synchroniser and edge detector, plus the active colour.
  // The edge detector reads the second stage and its delayed copy, never the first.
  logic line_meta_q;
  logic line_sync_q;
  logic line_prev_q;
  logic line_edge;
  cogr_colour_t colour_d;
  cogr_colour_t colour_q;

  assign line_edge = line_sync_q && !line_prev_q;

  // Fixed selects follow at once; the rotating select steps once per line.
  always_comb begin
    colour_d = colour_q;
    case (mux_sel)
      MUX_RED: colour_d = COL_RED;
      MUX_GREEN: colour_d = COL_GREEN;
      MUX_BLUE: colour_d = COL_BLUE;
      MUX_ROTATE: begin
        if (line_edge) begin
          case (colour_q)
            COL_RED: colour_d = COL_GREEN;
            COL_GREEN: colour_d = COL_BLUE;
            COL_BLUE: colour_d = COL_RED;
            default: colour_d = COL_RED;
          endcase
        end
      end
      default: colour_d = COL_RED;
    endcase
  end

  // Colour state and line sync flops.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      line_meta_q <= 1'b0;
      line_sync_q <= 1'b0;
      line_prev_q <= 1'b0;
      colour_q <= COL_RED;
    end else if (ce_i) begin
      line_meta_q <= line_sync_i;
      line_sync_q <= line_meta_q;
      line_prev_q <= line_sync_q;
      colour_q <= colour_d;
    end
  end

  // Registered outputs: readback, selected codes and output pins.
  logic [DATA_W-1:0] rdata_d;
  logic [CODE_W-1:0] offset_d;
  logic [CODE_W-1:0] gain_d;
  logic [3:0] nibble_d;

  // The gain law is analogue; only the code travels here, and
  // code zero gives the least gain.
  always_comb begin
    rdata_d = '0;
    if (rd_i) begin
      case (addr_i)
        ADR_RED_OFS: rdata_d = DATA_W'(val[SLOT_RED_OFS]);
        ADR_GRN_OFS: rdata_d = DATA_W'(val[SLOT_GRN_OFS]);
        ADR_BLU_OFS: rdata_d = DATA_W'(val[SLOT_BLU_OFS]);
        ADR_RED_GAIN: rdata_d = DATA_W'(val[SLOT_RED_GAIN]);
        ADR_GRN_GAIN: rdata_d = DATA_W'(val[SLOT_GRN_GAIN]);
        ADR_BLU_GAIN: rdata_d = DATA_W'(val[SLOT_BLU_GAIN]);
        ADR_CTRL: rdata_d = DATA_W'(ctrl_q);
        ADR_STAT: rdata_d = DATA_W'(colour_q);
        default: rdata_d = '0; // Broadcast and unmapped read as zero.
      endcase
    end
    case (colour_q)
      COL_RED: begin
        offset_d = val[SLOT_RED_OFS];
        gain_d = val[SLOT_RED_GAIN];
      end
      COL_GREEN: begin
        offset_d = val[SLOT_GRN_OFS];
        gain_d = val[SLOT_GRN_GAIN];
      end
      COL_BLUE: begin
        offset_d = val[SLOT_BLU_OFS];
        gain_d = val[SLOT_BLU_GAIN];
      end
      default: begin
        offset_d = RST_OFS;
        gain_d = RST_GAIN;
      end
    endcase
    if (test_en) begin
      nibble_d = {sample_sync_i, video_clk_i, conv_clk_i, reset_clk_i};
    end else begin
      nibble_d = conv_nibble_i;
    end
  end

  // Output flops; every output leaves straight from here.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
      offset_code_o <= RST_OFS;
      gain_value_o <= RST_GAIN;
      active_colour_o <= COL_RED;
      nibble_data_out_o <= '0;
    end else if (ce_i) begin
      rdata_o <= rdata_d;
      offset_code_o <= offset_d;
      gain_value_o <= gain_d;
      active_colour_o <= colour_d;
      nibble_data_out_o <= nibble_d;
    end
  end

  // Checks on the stored codes and what leaves the bank.
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_wr_all_ofs;
    ce_i && wr_i && addr_i == ADR_ALL_OFS;
  endsequence

  sequence s_wr_all_gain;
    ce_i && wr_i && addr_i == ADR_ALL_GAIN;
  endsequence

  sequence s_test_cycle;
    ce_i && test_en;
  endsequence

  sequence s_after_reset;
    $past(!rstn_i);
  endsequence

  a_red_ofs_reset: assert property ($past(!rstn_i) |-> val[SLOT_RED_OFS] == 8'h80
      && offset_code_o == 8'h80)
    else $error("red offset not 80 after reset");
  a_red_ofs_write: assert property (ce_i && wr_i && addr_i == ADR_RED_OFS
      |=> val[SLOT_RED_OFS] == $past(wcode))
    else $error("red offset write lost");
  a_grn_ofs_write: assert property (ce_i && wr_i && addr_i == ADR_GRN_OFS
      |=> val[SLOT_GRN_OFS] == $past(wcode) && val[SLOT_RED_OFS] == $past(val[SLOT_RED_OFS]))
    else $error("green offset write wrong");
  a_blu_ofs_reset: assert property ($past(!rstn_i) |-> val[SLOT_BLU_OFS] == 8'h80
      && val[SLOT_GRN_OFS] == 8'h80)
    else $error("green or blue offset not 80 after reset");
  a_blu_ofs_write: assert property (ce_i && wr_i && addr_i == ADR_BLU_OFS
      |=> val[SLOT_BLU_OFS] == $past(wcode))
    else $error("blue offset write lost");
  a_bcast_ofs_all: assert property (s_wr_all_ofs |=> val[SLOT_RED_OFS] == $past(wcode)
      && val[SLOT_GRN_OFS] == $past(wcode) && val[SLOT_BLU_OFS] == $past(wcode))
    else $error("combined offset write missed a colour");
  a_red_gain_reset: assert property (s_after_reset |-> val[SLOT_RED_GAIN] == RST_GAIN
      && gain_value_o == RST_GAIN)
    else $error("red gain not zero after reset");
  a_red_gain_write: assert property (ce_i && wr_i && addr_i == ADR_RED_GAIN
      |=> val[SLOT_RED_GAIN] == $past(wcode))
    else $error("red gain write lost");
  a_grn_gain_write: assert property (ce_i && wr_i && addr_i == ADR_GRN_GAIN
      |=> val[SLOT_GRN_GAIN] == $past(wcode))
    else $error("green gain write lost");
  a_blu_gain_write: assert property (ce_i && wr_i && addr_i == ADR_BLU_GAIN
      |=> val[SLOT_BLU_GAIN] == $past(wcode) && val[SLOT_GRN_GAIN] == $past(val[SLOT_GRN_GAIN]))
    else $error("blue gain write wrong");
  a_bcast_gain_all: assert property (s_wr_all_gain |=> val[SLOT_RED_GAIN] == $past(wcode)
      && val[SLOT_GRN_GAIN] == $past(wcode) && val[SLOT_BLU_GAIN] == $past(wcode))
    else $error("combined gain write missed a colour");
  a_test_top_bit: assert property (s_test_cycle |=> nibble_data_out_o[3] == $past(sample_sync_i))
    else $error("sample sync not on output bit 3 in test mode");
  a_test_low_bits: assert property (s_test_cycle |=> nibble_data_out_o[2:0]
      == {$past(video_clk_i), $past(conv_clk_i), $past(reset_clk_i)})
    else $error("test clocks not on output bits 2..0");
  a_normal_data: assert property (ce_i && !test_en |=> nibble_data_out_o == $past(conv_nibble_i))
    else $error("normal data not passed with test bit clear");
  a_mux_blue_sel: assert property (ce_i && colour_q == COL_BLUE
      |=> offset_code_o == $past(val[SLOT_BLU_OFS]) && gain_value_o == $past(val[SLOT_BLU_GAIN]))
    else $error("blue codes not selected");
  a_mux_fixed_sel: assert property (ce_i && mux_sel == MUX_GREEN
      ##1 ce_i && mux_sel == MUX_GREEN
      |=> active_colour_o == COL_GREEN && offset_code_o == $past(val[SLOT_GRN_OFS]))
    else $error("green select did not take effect");
  a_read_gain: assert property (ce_i && rd_i && addr_i == ADR_RED_GAIN
      |=> rdata_o == DATA_W'($past(val[SLOT_RED_GAIN])))
    else $error("red gain readback wrong");
  a_read_grn_ofs: assert property (ce_i && rd_i && addr_i == ADR_GRN_OFS
      |=> rdata_o == DATA_W'($past(val[SLOT_GRN_OFS])))
    else $error("green offset readback wrong");
  a_mux_red_sel: assert property (ce_i && colour_q == COL_RED
      |=> offset_code_o == $past(val[SLOT_RED_OFS]) && gain_value_o == $past(val[SLOT_RED_GAIN]))
    else $error("red codes not selected");
  a_mux_grn_sel: assert property (ce_i && colour_q == COL_GREEN
      |=> offset_code_o == $past(val[SLOT_GRN_OFS]) && gain_value_o == $past(val[SLOT_GRN_GAIN]))
    else $error("green codes not selected");
  // The rotating colour may move only on a synchronised line edge, so a pin glitch
  // that the synchroniser swallows can never skip a colour.
  a_rotate_hold: assert property (ce_i && mux_sel == MUX_ROTATE && !line_edge
      |=> colour_q == $past(colour_q))
    else $error("rotating colour moved without a line edge");
  a_rotate_wrap: assert property (ce_i && mux_sel == MUX_ROTATE && line_edge
      && colour_q == COL_BLUE |=> colour_q == COL_RED)
    else $error("rotating colour did not wrap from blue to red");
  // A stalled front end must keep its colour and codes while the enable is low.
  a_ce_freeze: assert property (!ce_i |=> $stable(colour_q) && $stable(offset_code_o)
      && $stable(gain_value_o))
    else $error("colour path moved with the clock enable low");

endmodule // cogr_bank
`default_nettype wire

//--- bench/cogr_host.sv
// Host controller model that drives the bank's plain register port.
`timescale 1ns/1ps
`default_nettype none
module cogr_host
  import cogr_pkg::*;
(
  input wire logic clk_sys_i, // System clock.
  output logic [ADR_W-1:0] addr_o, // Register address.
  output logic [CODE_W-1:0] wdata_o, // Write data.
  output logic wr_o, // Write strobe.
  output logic rd_o, // Read strobe.
  input wire logic [CODE_W-1:0] rdata_i // Read data from the bank.
);
  // Idle bus at time zero.
  initial begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One write; address and data flip afterwards so a stale value never looks valid.
  task automatic wr_reg(input logic [ADR_W-1:0] a, input logic [CODE_W-1:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // One read; the data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_reg(input logic [ADR_W-1:0] a, output logic [CODE_W-1:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule // cogr_host
`default_nettype wire

//--- bench/cogr_bank_tb.sv
// Self-checking testbench of the colour offset and gain register bank.
`timescale 1ns/1ps
`default_nettype none
module cogr_bank_tb;
  import cogr_pkg::*;
  logic clk_sys_i, rstn_i, ce_i, line_sync_i, wr, rd;
  logic [3:0] conv_nibble_i, tim, pin_o;
  logic [ADR_W-1:0] addr;
  logic [7:0] wdata, rdata, ofs_o, gain_o;
  logic [2:0] colour_o;
  int bad_count, n_tests;

  // Free-running 250 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  cogr_host host (.clk_sys_i(clk_sys_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdata));

  cogr_bank #(.DATA_W(8)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .line_sync_i(line_sync_i), .conv_nibble_i(conv_nibble_i), .sample_sync_i(tim[3]),
    .video_clk_i(tim[2]), .conv_clk_i(tim[1]), .reset_clk_i(tim[0]), .offset_code_o(ofs_o),
    .gain_value_o(gain_o), .active_colour_o(colour_o), .nibble_data_out_o(pin_o));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [ADR_W-1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd_reg(a, v);
    chk(v, exp, "register read");
  endtask

  // Lets n edges pass and settles just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs far fewer cycles.
  initial begin
    #200000;
    bad_count++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end

  // Main sequence.
  initial begin
    rstn_i = 1'b0;
    ce_i = 1'b1;
    line_sync_i = 1'b0;
    conv_nibble_i = 4'h0;
    tim = 4'h0;
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    tick(1);
    // Reset values, then one distinct value per slot.
    for (int i = 0; i < 6; i++) rchk(SLOT_ADR[i], (i < 3) ? 8'h80 : 8'h00);
    chk(ofs_o, 8'h80, "offset at reset");
    chk(gain_o, 8'h00, "gain at reset");
    for (int i = 0; i < 6; i++) host.wr_reg(SLOT_ADR[i], 8'h10 + 8'(i));
    for (int i = 0; i < 6; i++) rchk(SLOT_ADR[i], 8'h10 + 8'(i));
    host.wr_reg(ADR_ALL_OFS, 8'h55);
    for (int i = 0; i < 6; i++) rchk(SLOT_ADR[i], (i < 3) ? 8'h55 : 8'h10 + 8'(i));
    host.wr_reg(ADR_ALL_GAIN, 8'hFF);
    for (int i = 0; i < 6; i++) rchk(SLOT_ADR[i], (i < 3) ? 8'h55 : 8'hFF);
    // Broadcast places are write-only and unmapped places read zero.
    rchk(ADR_ALL_OFS, 8'h00);
    rchk(ADR_ALL_GAIN, 8'h00);
    host.wr_reg(4'hC, 8'hAA);
    rchk(4'hC, 8'h00);
    // Each fixed selection routes its own colour's codes to the path.
    for (int i = 0; i < 6; i++) host.wr_reg(SLOT_ADR[i], 8'h21 + 8'(i));
    for (int c = 0; c < 3; c++) begin
      host.wr_reg(ADR_CTRL, 8'(c));
      tick(4);
      chk({5'h00, colour_o}, 8'h01 << c, "colour");
      chk(ofs_o, 8'h21 + 8'(c), "offset path");
      chk(gain_o, 8'h24 + 8'(c), "gain path");
      rchk(ADR_STAT, 8'h01 << c);
    end
    host.wr_reg(ADR_STAT, 8'hFF);
    rchk(ADR_STAT, 8'h04);
    // Rotation: colour holds without line edges, then steps once per rising edge.
    host.wr_reg(ADR_CTRL, 8'h00);
    tick(4);
    host.wr_reg(ADR_CTRL, 8'h03);
    tick(8);
    chk({5'h00, colour_o}, 8'h01, "rotate hold");
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_sys_i);
      line_sync_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      line_sync_i <= 1'b0;
      tick(8);
      chk({5'h00, colour_o}, 8'h01 << (k % 3), "rotate colour");
      chk(gain_o, 8'h24 + 8'(k % 3), "rotate gain");
    end
    // Clock test mode puts the timing levels on the pins; clearing it restores data.
    host.wr_reg(ADR_CTRL, 8'hFF);
    rchk(ADR_CTRL, 8'h83);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys_i);
      tim <= (p == 0) ? 4'hA : 4'h6;
      conv_nibble_i <= (p == 0) ? 4'h5 : 4'h9;
      tick(3);
      chk({4'h0, pin_o}, (p == 0) ? 8'h0A : 8'h06, "test pins");
    end
    host.wr_reg(ADR_CTRL, 8'h00);
    tick(3);
    chk({4'h0, pin_o}, 8'h09, "data pins");
    // A write strobe with the clock enable low is ignored.
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    host.wr_reg(ADR_RED_OFS, 8'h99);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    rchk(ADR_RED_OFS, 8'h21);
    // A second reset in mid-run restores the stored codes.
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    tick(1);
    rchk(ADR_GRN_OFS, 8'h80);
    rchk(ADR_BLU_GAIN, 8'h00);
    conclude();
  end
endmodule // cogr_bank_tb
`default_nettype wire
